// ---- common/ihp_pkg.sv ----
// Purpose: shared constants and carriers for the ISA/EISA host bus port
// Assumes: one core clock at 25 MHz, synchronous active-high reset
// Notes: host pins are grouped in one struct so they share one synchroniser
package ihp_pkg;

   localparam int CLK_HZ = 25_000_000;
   localparam int SYNC_STAGES = 3;
   localparam int FIFO_DEPTH = 8;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int ISA_LANES = 2;

   // Address field positions
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB_ISA = 1;
   localparam int ADDR_LSB_EISA = 2;
   localparam int WIN_LSB = 4;

   // Values after reset
   localparam logic ASYNC_READY_OUT_RST = 1'b1;
   localparam logic LDEV_N_RST = 1'b1;
   localparam logic [3:0] BE_N_IDLE = 4'hF;
   localparam logic [3:0] OE_RST = 4'h0;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   localparam logic [15:1] ADDR_RST = 15'h0000;

   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic ads_n;
      logic qual;
      logic dack_n;
      logic exrdy;
      logic eisa;
      logic [3:0] be_n;
      logic [15:1] addr;
      logic [31:0] data;
   } ihp_pins_t;

   localparam ihp_pins_t PINS_RST = '{
      rd_n: 1'b1, wr_n: 1'b1, ads_n: 1'b1, qual: 1'b1, dack_n: 1'b1,
      exrdy: 1'b1, eisa: 1'b0, be_n: 4'hF, addr: 15'h0000, data: 32'h0000_0000};

   // One write toward the register file or packet buffer
   typedef struct packed {
      logic [15:1] addr;
      logic [3:0] be_n;
      logic [31:0] data;
      logic dma;
   } ihp_acc_t;

   localparam int ACC_W = $bits(ihp_acc_t);
   localparam ihp_acc_t ACC_RST = '{addr: 15'h0000, be_n: 4'hF, data: 32'h0000_0000, dma: 1'b0};

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_WAIT,
      ST_RD_HOLD,
      ST_WR_HOLD,
      ST_WR_PUSH
   } ihp_state_t;

endpackage

// ---- src/ihp_fifo.sv ----
// Purpose: write buffer between host strobes and the internal access port
// Assumes: DEPTH is a power of two
// Notes: output word is registered, so the consumer sees flop outputs
`timescale 1ns/1ns
module ihp_fifo #(
   parameter int WIDTH = 52,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;
   logic push;
   logic pop;

   assign in_ready_o = (count_q != CW'(DEPTH));
   assign push = in_valid_i && in_ready_o;
   // Refill the output stage whenever it is empty or being taken
   assign pop = (count_q != '0) && (!out_valid_o || out_ready_i);

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         count_q <= count_q + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem_q[rd_ptr_q];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end

endmodule

// ---- src/ihp_host_port.sv ----
// Purpose: ISA (16-bit) / EISA (32-bit slave with DMA) host bus port
// Assumes: host strobes are asynchronous to core_clk_i; internal side is synchronous
// Notes: writes are buffered, reads go straight to the internal read port
`timescale 1ns/1ns
module ihp_host_port (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Host strobes and qualifiers
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic address_strobe_n_i,
   input wire logic io_decode_qualifier_i,
   input wire logic [3:0] byte_lane_select_n_i,
   input wire logic [15:1] addr_i,
   // Host data bus, split into three signals
   input wire logic [31:0] data_i,
   output logic [31:0] data_o,
   output logic [3:0] data_oe_o,
   // Host handshake and decode
   output logic async_ready_out_o,
   output logic local_device_decode_n_o,
   // EISA DMA and mode
   input wire logic dma_ack_n_i,
   input wire logic exrdy_i,
   input wire logic eisa_mode_i,
   // I/O window base from configuration
   input wire logic [15:4] io_base_i,
   // Internal read port
   output logic rd_req_o,
   output logic [15:1] rd_addr_o,
   output logic [3:0] rd_be_n_o,
   input wire logic rd_valid_i,
   input wire logic [31:0] rd_data_i,
   // Internal write port
   output logic acc_valid_o,
   input wire logic acc_ready_i,
   output ihp_pkg::ihp_acc_t acc_o
);

   ihp_pkg::ihp_pins_t pins_raw;
   ihp_pkg::ihp_pins_t s1_q;
   ihp_pkg::ihp_pins_t s2_q;
   ihp_pkg::ihp_pins_t s3_q;
   ihp_pkg::ihp_pins_t pin_q;
   ihp_pkg::ihp_pins_t prev_q;
   logic [$bits(ihp_pkg::ihp_pins_t)-1:0] pin_agree;

   ihp_pkg::ihp_state_t state_q;
   logic async_ready_out_q;
   logic ldev_n_q;
   logic rd_req_q;
   logic [15:1] rd_addr_q;
   logic [3:0] rd_be_n_q;
   logic [31:0] dout_q;
   logic [3:0] oe_q;

   logic [15:1] lat_addr_q;
   logic [3:0] lat_be_n_q;
   logic lat_qual_q;
   logic [15:1] eff_addr;
   logic [3:0] eff_be_n;
   logic eff_qual;
   logic hit;

   logic rd_fall;
   logic rd_rise;
   logic wr_fall;
   logic wr_rise;
   logic ads_rise;
   logic in_dma;
   logic eisa;

   logic [15:1] wr_addr_q;
   logic [3:0] wr_be_n_q;
   ihp_pkg::ihp_acc_t push_q;
   logic push_valid_q;
   logic fifo_ready;
   ihp_pkg::ihp_acc_t dma_word_q;
   logic dma_pend_q;
   logic [3:0] lane_en;
   logic [31:0] lane_mask;

   assign pins_raw = '{
      rd_n: read_strobe_n_i, wr_n: write_strobe_n_i, ads_n: address_strobe_n_i,
      qual: io_decode_qualifier_i, dack_n: dma_ack_n_i, exrdy: exrdy_i, eisa: eisa_mode_i,
      be_n: byte_lane_select_n_i, addr: addr_i, data: data_i};

   // Three stages; a bit changes only once stages two and three agree
   assign pin_agree = ~(s2_q ^ s3_q);

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s1_q <= ihp_pkg::PINS_RST;
         s2_q <= ihp_pkg::PINS_RST;
         s3_q <= ihp_pkg::PINS_RST;
         pin_q <= ihp_pkg::PINS_RST;
      end else begin
         s1_q <= pins_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= (s3_q & pin_agree) | (pin_q & ~pin_agree);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         prev_q <= ihp_pkg::PINS_RST;
      end else begin
         prev_q <= pin_q;
      end
   end

   assign eisa = pin_q.eisa;
   assign in_dma = eisa && !pin_q.dack_n;
   assign rd_fall = prev_q.rd_n && !pin_q.rd_n;
   assign rd_rise = !prev_q.rd_n && pin_q.rd_n;
   assign wr_fall = prev_q.wr_n && !pin_q.wr_n;
   assign wr_rise = !prev_q.wr_n && pin_q.wr_n;
   assign ads_rise = !prev_q.ads_n && pin_q.ads_n;

   // Address, lanes and qualifier held from the strobe's rising edge
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         lat_addr_q <= ihp_pkg::ADDR_RST;
         lat_be_n_q <= ihp_pkg::BE_N_IDLE;
         lat_qual_q <= 1'b1;
      end else if (ads_rise) begin
         lat_addr_q <= pin_q.addr;
         lat_be_n_q <= pin_q.be_n;
         lat_qual_q <= pin_q.qual;
      end
   end

   // ISA ties the address strobe low, so the path stays transparent there
   always_comb begin
      eff_addr = pin_q.ads_n ? lat_addr_q : pin_q.addr;
      eff_be_n = pin_q.ads_n ? lat_be_n_q : pin_q.be_n;
      eff_qual = pin_q.ads_n ? lat_qual_q : pin_q.qual;
      if (eisa) begin
         eff_addr[ihp_pkg::ADDR_LSB_ISA] = 1'b0;
      end else begin
         eff_be_n[3:2] = 2'h3;
      end
   end

   // One qualifier covers both memory/IO and address enable
   assign hit = !eff_qual && (eff_addr[ihp_pkg::ADDR_MSB:ihp_pkg::WIN_LSB] == io_base_i);
   assign lane_en = ~eff_be_n;

   always_comb begin
      for (int i = 0; i < ihp_pkg::LANES; i++) begin
         lane_mask[8*i +: 8] = {8{lane_en[i]}};
      end
   end

   // Totem-pole; external open-collector buffer shares the line
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ldev_n_q <= ihp_pkg::LDEV_N_RST;
      end else begin
         ldev_n_q <= !hit;
      end
   end

   // Access sequencer: read request, write hold and ready
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_q <= ihp_pkg::ST_IDLE;
         async_ready_out_q <= ihp_pkg::ASYNC_READY_OUT_RST;
         rd_req_q <= 1'b0;
         rd_addr_q <= ihp_pkg::ADDR_RST;
         rd_be_n_q <= ihp_pkg::BE_N_IDLE;
         wr_addr_q <= ihp_pkg::ADDR_RST;
         wr_be_n_q <= ihp_pkg::BE_N_IDLE;
      end else begin
         rd_req_q <= 1'b0;
         case (state_q)
            ihp_pkg::ST_IDLE: begin
               async_ready_out_q <= 1'b1;
               // Read strobe is assumed idle during DMA bursts
               if (rd_fall && hit && !in_dma) begin
                  rd_req_q <= 1'b1;
                  rd_addr_q <= eff_addr;
                  rd_be_n_q <= eff_be_n;
                  async_ready_out_q <= eisa;
                  state_q <= ihp_pkg::ST_RD_WAIT;
               end else if (wr_fall && hit && !in_dma) begin
                  wr_addr_q <= eff_addr;
                  wr_be_n_q <= eff_be_n;
                  async_ready_out_q <= eisa || (fifo_ready && !push_valid_q);
                  state_q <= ihp_pkg::ST_WR_HOLD;
               end
            end
            ihp_pkg::ST_RD_WAIT: begin
               if (rd_rise) begin
                  async_ready_out_q <= 1'b1;
                  state_q <= ihp_pkg::ST_IDLE;
               end else if (rd_valid_i) begin
                  async_ready_out_q <= 1'b1;
                  state_q <= ihp_pkg::ST_RD_HOLD;
               end
            end
            ihp_pkg::ST_RD_HOLD: begin
               if (rd_rise) begin
                  state_q <= ihp_pkg::ST_IDLE;
               end
            end
            ihp_pkg::ST_WR_HOLD: begin
               if (fifo_ready && !push_valid_q) begin
                  async_ready_out_q <= 1'b1;
               end
               if (wr_rise) begin
                  state_q <= ihp_pkg::ST_WR_PUSH;
               end
            end
            ihp_pkg::ST_WR_PUSH: begin
               if (!push_valid_q) begin
                  state_q <= ihp_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= ihp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Read data lanes: only the enabled lanes are driven
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         dout_q <= ihp_pkg::DATA_RST;
         oe_q <= ihp_pkg::OE_RST;
      end else if (state_q == ihp_pkg::ST_RD_WAIT && rd_valid_i && !rd_rise) begin
         dout_q <= rd_data_i;
         oe_q <= ~rd_be_n_q;
      end else if (rd_rise || state_q == ihp_pkg::ST_IDLE) begin
         oe_q <= ihp_pkg::OE_RST;
      end
   end

   // DMA word waits here while the bus asks for wait states
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         dma_pend_q <= 1'b0;
         dma_word_q <= ihp_pkg::ACC_RST;
      end else if (in_dma && wr_rise) begin
         dma_pend_q <= 1'b1;
         dma_word_q <= '{addr: eff_addr, be_n: 4'h0, data: pin_q.data, dma: 1'b1};
      end else if (dma_pend_q && pin_q.exrdy && !push_valid_q) begin
         dma_pend_q <= 1'b0;
      end
   end

   // Single push register feeds the buffer; I/O writes and DMA never overlap
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         push_valid_q <= 1'b0;
         push_q <= ihp_pkg::ACC_RST;
      end else if (push_valid_q) begin
         if (fifo_ready) begin
            push_valid_q <= 1'b0;
         end
      end else if (state_q == ihp_pkg::ST_WR_HOLD && wr_rise) begin
         push_valid_q <= 1'b1;
         push_q <= '{addr: wr_addr_q, be_n: wr_be_n_q, data: pin_q.data & lane_mask, dma: 1'b0};
      end else if (dma_pend_q && pin_q.exrdy) begin
         push_valid_q <= 1'b1;
         push_q <= dma_word_q;
      end
   end

   ihp_fifo #(
      .WIDTH(ihp_pkg::ACC_W),
      .DEPTH(ihp_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(push_valid_q),
      .in_ready_o(fifo_ready),
      .in_data_i(push_q),
      .out_valid_o(acc_valid_o),
      .out_ready_i(acc_ready_i),
      .out_data_o(acc_o)
   );

   assign data_o = dout_q;
   assign data_oe_o = oe_q;
   assign async_ready_out_o = async_ready_out_q;
   assign local_device_decode_n_o = ldev_n_q;
   assign rd_req_o = rd_req_q;
   assign rd_addr_o = rd_addr_q;
   assign rd_be_n_o = rd_be_n_q;

endmodule

// ---- verification/ihp_host_port_props.sv ----
// Purpose: port checks of the host bus port
// Assumes: bound to ihp_host_port, one clock
// Notes: lags allow for the 3-flop pin sync
`timescale 1ns/1ns
module ihp_host_port_props (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Watched inputs
   input wire logic io_decode_qualifier_i,
   input wire logic eisa_mode_i,
   input wire logic dma_ack_n_i,
   input wire logic exrdy_i,
   input wire logic [15:4] io_base_i,
   input wire logic rd_valid_i,
   input wire logic [31:0] rd_data_i,
   input wire logic acc_ready_i,
   // Watched outputs
   input wire logic async_ready_out_o,
   input wire logic local_device_decode_n_o,
   input wire logic [31:0] data_o,
   input wire logic [3:0] data_oe_o,
   input wire logic rd_req_o,
   input wire logic [15:1] rd_addr_o,
   input wire logic [3:0] rd_be_n_o,
   input wire logic acc_valid_o,
   input wire ihp_pkg::ihp_acc_t acc_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   AST_QUAL: assert property (
      $fell(local_device_decode_n_o) && !eisa_mode_i |-> $past(!io_decode_qualifier_i, 4))
      else $error("decode with qualifier high");
   AST_WIN: assert property (rd_req_o |-> rd_addr_o[15:4] == io_base_i)
      else $error("read outside window");
   AST_RDY_DROP: assert property (!eisa_mode_i && rd_req_o |-> !async_ready_out_o)
      else $error("ready not dropped");
   AST_RDY_RISE: assert property (
      !eisa_mode_i && !async_ready_out_o && rd_valid_i |=> async_ready_out_o)
      else $error("ready not raised");
   AST_RD_DATA: assert property ($rose(data_oe_o[0]) |-> data_o[7:0] == $past(rd_data_i[7:0]))
      else $error("read data wrong");
   AST_LANES: assert property ($rose(data_oe_o != 4'h0) |-> data_oe_o == ~rd_be_n_o)
      else $error("lane enables wrong");
   AST_ISA_UP: assert property (!eisa_mode_i && $past(!eisa_mode_i, 8) |-> data_oe_o[3:2] == 2'h0)
      else $error("upper lanes driven");
   AST_EISA_RDY: assert property (eisa_mode_i && $past(eisa_mode_i, 8) |-> async_ready_out_o)
      else $error("ready dropped in 32-bit mode");
   AST_HOLD: assert property (acc_valid_o && !acc_ready_i |=> acc_valid_o && $stable(acc_o))
      else $error("write word not held");
   AST_DMA_BE: assert property (acc_valid_o && acc_o.dma |-> acc_o.be_n == 4'h0)
      else $error("burst word not doubleword");
   AST_DMA_WAIT: assert property ((!dma_ack_n_i && !exrdy_i) [*8] |-> !$rose(acc_valid_o))
      else $error("burst word during wait");
endmodule

// ---- verification/ihp_host_model.sv ----
// Purpose: host bus and glue driving the port pins
// Assumes: pins change just after a clock edge
// Notes: long strobes, since the port sees pins through a sync
`timescale 1ns/1ns
module ihp_host_model (
   // Clock
   input wire logic core_clk_i,
   // Pins and answers
   output ihp_pkg::ihp_pins_t pins_o,
   input wire logic ready_i,
   input wire logic [31:0] rdata_i,
   input wire logic [3:0] oe_i
);
   initial pins_o = ihp_pkg::PINS_RST;
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // 16-bit wiring ties the address strobe low
   task automatic mode(input logic e);
      pins_o.eisa <= e;
      pins_o.ads_n <= e;
      hold(8);
   endtask
   task automatic ctl(input logic dk, input logic ex);
      pins_o.dack_n <= dk;
      pins_o.exrdy <= ex;
      hold(4);
   endtask
   // Address set before the strobe, strobe held 10+ clocks
   task automatic cycle(input logic w, input logic q, input logic [15:1] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] rd, output logic [3:0] oe);
      pins_o.addr <= a;
      pins_o.be_n <= be;
      pins_o.qual <= q;
      pins_o.data <= d;
      hold(5);
      if (pins_o.eisa) begin
         pins_o.ads_n <= 1'b0;
         hold(4);
         pins_o.ads_n <= 1'b1;
         hold(2);
         // Pins scrambled after the latch; the glue ORs qualifier high
         pins_o.addr <= {~a[15:2], a[1]};
         pins_o.qual <= 1'b1;
         hold(4);
      end
      if (w) pins_o.wr_n <= 1'b0;
      else pins_o.rd_n <= 1'b0;
      hold(12);
      for (int n = 0; n < 200 && ready_i !== 1'b1; n++) hold(1);
      rd = rdata_i;
      oe = oe_i;
      pins_o.rd_n <= 1'b1;
      pins_o.wr_n <= 1'b1;
      hold(6);
      pins_o.data <= ~d;
      hold(4);
   endtask
   // Burst word on write strobe only, read strobe idle
   task automatic dma(input logic [31:0] d);
      pins_o.data <= d;
      hold(4);
      pins_o.wr_n <= 1'b0;
      hold(4);
      pins_o.wr_n <= 1'b1;
      hold(4);
      pins_o.data <= ~d;
      // Let an edge pass so back-to-back words never retarget data in one step
      hold(1);
   endtask
endmodule

// ---- verification/ihp_host_port_tb.sv ----
// Purpose: self-checking bench of the host bus port
// Assumes: host model drives pins, bench answers the internal side
// Notes: burst word address is not compared
`timescale 1ns/1ns
module ihp_host_port_tb;
   typedef struct packed {
      logic e;
      logic w;
      logic [3:0] be;
      logic [15:1] a;
      logic [31:0] d;
   } ihp_row_t;
   localparam ihp_row_t ROWS [9] = '{
      '{1'b0, 1'b1, 4'hC, 15'h0181, 32'h1234_ABCD}, '{1'b0, 1'b1, 4'hE, 15'h0182, 32'h1234_ABCD},
      '{1'b0, 1'b1, 4'h1, 15'h0183, 32'h55AA_7E81}, '{1'b0, 1'b0, 4'hC, 15'h0184, 32'h0},
      '{1'b0, 1'b0, 4'hD, 15'h0185, 32'h0}, '{1'b1, 1'b1, 4'h0, 15'h0184, 32'h8765_4321},
      '{1'b1, 1'b1, 4'h3, 15'h0186, 32'h2468_ACE0}, '{1'b1, 1'b0, 4'h0, 15'h0186, 32'h0},
      '{1'b1, 1'b0, 4'h6, 15'h0184, 32'h0}};
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   ihp_pkg::ihp_pins_t pins;
   logic [31:0] dout, rd_d = 32'h0, rd;
   logic [3:0] oe, rd_be, m, o;
   logic rdy, ldev, rd_req, rd_v = 1'b0, acc_v, acc_rdy = 1'b1, ldev_seen, stall;
   logic [15:1] rd_a;
   logic [1:0] dly = 2'h0;
   ihp_pkg::ihp_acc_t acc;
   ihp_pkg::ihp_acc_t got [$];
   ihp_pkg::ihp_acc_t ex [$];
   ihp_row_t r;
   int fail_count = 0, n_compared = 0, cyc = 0, rd_cnt = 0, n;
   initial forever #20 core_clk_i = ~core_clk_i;
   ihp_host_model i_host (.core_clk_i(core_clk_i), .pins_o(pins), .ready_i(rdy), .rdata_i(dout), .oe_i(oe));
   ihp_host_port i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .read_strobe_n_i(pins.rd_n),
      .write_strobe_n_i(pins.wr_n), .address_strobe_n_i(pins.ads_n), .io_decode_qualifier_i(pins.qual),
      .byte_lane_select_n_i(pins.be_n), .addr_i(pins.addr), .data_i(pins.data), .data_o(dout),
      .data_oe_o(oe), .async_ready_out_o(rdy), .local_device_decode_n_o(ldev), .dma_ack_n_i(pins.dack_n),
      .exrdy_i(pins.exrdy), .eisa_mode_i(pins.eisa), .io_base_i(12'h030), .rd_req_o(rd_req),
      .rd_addr_o(rd_a), .rd_be_n_o(rd_be), .rd_valid_i(rd_v), .rd_data_i(rd_d), .acc_valid_o(acc_v),
      .acc_ready_i(acc_rdy), .acc_o(acc));
   function automatic logic [31:0] pat(input logic [15:1] a);
      return {a, 1'b0, a, 1'b0};
   endfunction
   function automatic logic [31:0] bytes(input logic [3:0] k);
      return {{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
   endfunction
   task automatic chk_val(input logic [63:0] g, input logic [63:0] x);
      n_compared++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR %0t value %h expected %h", $time, g, x);
      end
   endtask
   task automatic chk_acc();
      ihp_pkg::ihp_acc_t g, x;
      x = ex.pop_front();
      g = (got.size() > 0) ? got.pop_front() : ~x;
      if (x.dma) x.addr = g.addr;
      n_compared++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR %0t write word %h expected %h", $time, g, x);
      end
   endtask
   task automatic end_sim();
      if (fail_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Internal side: read data three clocks after the request
   always @(posedge core_clk_i) begin
      dly <= {dly[0], rd_req};
      rd_v <= dly[1];
      rd_d <= pat(rd_a);
      if (rd_req === 1'b1) rd_cnt++;
      if (ldev === 1'b0) ldev_seen = 1'b1;
      if (acc_v === 1'b1 && acc_rdy) got.push_back(acc);
      cyc++;
      if (cyc == 10000) begin
         fail_count++;
         end_sim();
      end
   end
   initial begin
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk_val({rdy, ldev, oe, acc_v, rd_req}, 8'hC0);
      @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      foreach (ROWS[i]) begin
         r = ROWS[i];
         m = r.e ? ~r.be : {2'h0, ~r.be[1:0]};
         i_host.mode(r.e);
         ldev_seen = 1'b0;
         if (r.w) ex.push_back('{r.a, ~m, r.d & bytes(m), 1'b0});
         i_host.cycle(r.w, 1'b0, r.a, r.be, r.d, rd, o);
         repeat (20) @(posedge core_clk_i);
         if (r.w) chk_acc();
         else chk_val({o, rd & bytes(m)}, {m, pat(r.a) & bytes(m)});
         chk_val(ldev_seen, 1'b1);
      end
      i_host.mode(1'b0);
      n = rd_cnt;
      ldev_seen = 1'b0;
      i_host.cycle(1'b0, 1'b1, 15'h0181, 4'hC, 32'h0, rd, o);
      i_host.cycle(1'b0, 1'b0, 15'h0281, 4'hC, 32'h0, rd, o);
      i_host.cycle(1'b1, 1'b1, 15'h0181, 4'hC, 32'h77, rd, o);
      repeat (20) @(posedge core_clk_i);
      chk_val({16'(rd_cnt - n), ldev_seen, 16'(got.size())}, 0);
      acc_rdy <= 1'b0;
      stall = 1'b0;
      fork
         for (int k = 0; k < 14; k++) begin
            // Window spans eight word addresses, so the address wraps inside it
            ex.push_back('{{12'h030, 3'(k)}, 4'hC, 32'(32'hA000 + k), 1'b0});
            i_host.cycle(1'b1, 1'b0, {12'h030, 3'(k)}, 4'hC, 32'(32'hA000 + k), rd, o);
         end
         begin
            for (int t = 0; t < 4000 && rdy !== 1'b0; t++) @(posedge core_clk_i);
            stall = (rdy === 1'b0);
            repeat (20) @(posedge core_clk_i);
            acc_rdy <= 1'b1;
         end
      join
      repeat (30) @(posedge core_clk_i);
      for (int k = 0; k < 14; k++) chk_acc();
      chk_val(stall, 1'b1);
      i_host.mode(1'b1);
      i_host.ctl(1'b0, 1'b0);
      i_host.dma(32'h1357_9BDF);
      repeat (30) @(posedge core_clk_i);
      chk_val(got.size(), 0);
      ex.push_back('{15'h0, 4'h0, 32'h1357_9BDF, 1'b1});
      i_host.ctl(1'b0, 1'b1);
      for (int k = 0; k < 3; k++) begin
         ex.push_back('{15'h0, 4'h0, 32'(32'hC0 + k), 1'b1});
         i_host.dma(32'(32'hC0 + k));
      end
      i_host.ctl(1'b1, 1'b1);
      repeat (30) @(posedge core_clk_i);
      for (int k = 0; k < 4; k++) chk_acc();
      end_sim();
   end
endmodule
bind ihp_host_port ihp_host_port_props i_props (.core_clk_i, .sys_rst_i, .io_decode_qualifier_i,
   .eisa_mode_i, .dma_ack_n_i, .exrdy_i, .io_base_i, .rd_valid_i, .rd_data_i, .acc_ready_i,
   .async_ready_out_o, .local_device_decode_n_o, .data_o, .data_oe_o, .rd_req_o, .rd_addr_o,
   .rd_be_n_o, .acc_valid_o, .acc_o);
